// >>> hw/bstap_map.vh
// Constants for the boundary-scan test access port registers
`ifndef BSTAP_MAP_VH
`define BSTAP_MAP_VH

// ==========================================================
// Register lengths
`define BSTAP_IR_LEN 10
`define BSTAP_UC_LEN 32
`define BSTAP_ID_LEN 32
`define BSTAP_BSR_LEN_SMALL 1029
`define BSTAP_BSR_LEN_MID 1665
`define BSTAP_BSR_LEN_LARGE 1941

// ==========================================================
// Identification word field positions (MSB end first)
`define BSTAP_ID_VER_MSB 31
`define BSTAP_ID_VER_LSB 28
`define BSTAP_ID_PART_MSB 27
`define BSTAP_ID_PART_LSB 12
`define BSTAP_ID_MFR_MSB 11
`define BSTAP_ID_MFR_LSB 1
`define BSTAP_ID_FIXED_BIT 0

// Identity defaults; values are arbitrary
`define BSTAP_ID_VER_RST 4'h1
`define BSTAP_ID_PART_RST 16'h5A3C
`define BSTAP_ID_MFR_RST 11'h2B5

// ==========================================================
// Instruction codes, 10 bits each
`define BSTAP_OP_EXTEST 10'h000
`define BSTAP_OP_SAMPLE 10'h005
`define BSTAP_OP_IDCODE 10'h006
`define BSTAP_OP_USERCODE 10'h007
`define BSTAP_OP_CLAMP 10'h00A
`define BSTAP_OP_HIGHZ 10'h00B
`define BSTAP_OP_BYPASS 10'h3FF

// Value loaded into the instruction shifter on capture
`define BSTAP_IR_CAPTURE 10'h001

`endif

// >>> hw/bstap_regs.v
// Boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/100ps
`include "bstap_map.vh"


module bstap_regs #(
   parameter SIZE_VARIANT = 0,
   parameter NUM_IO = 8,
   parameter [3:0] ID_VERSION = `BSTAP_ID_VER_RST,
   parameter [15:0] ID_PART = `BSTAP_ID_PART_RST,
   parameter [10:0] ID_MAKER = `BSTAP_ID_MFR_RST
) (
   // Clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // Test port pins
   input wire i_tck,
   input wire i_tms,
   input wire i_tdi,
   output wire o_tdo,
   output wire o_tdo_oe,
   // Configuration and cell values
   input wire [31:0] i_usercode,
   input wire [bsr_len(SIZE_VARIANT)-1:0] i_bsr_capture,
   output wire [bsr_len(SIZE_VARIANT)-1:0] o_bsr_update,
   // User I/O from core logic
   input wire [NUM_IO-1:0] i_core_out,
   input wire [NUM_IO-1:0] i_core_oe,
   input wire [NUM_IO-1:0] i_keeper_en,
   // User I/O toward the pads
   output wire [NUM_IO-1:0] o_pin_out,
   output wire [NUM_IO-1:0] o_pin_oe,
   output wire [NUM_IO-1:0] o_keeper_on
);

   // ==========================================================
   // Helpers
   // Boundary length for the size variant
   function integer bsr_len;
      input integer variant;
      begin
         if (variant == 0) begin
            bsr_len = `BSTAP_BSR_LEN_SMALL;
         end else if (variant == 1) begin
            bsr_len = `BSTAP_BSR_LEN_MID;
         end else begin
            bsr_len = `BSTAP_BSR_LEN_LARGE;
         end
      end
   endfunction

   localparam BSR_LEN = bsr_len(SIZE_VARIANT);

   // One-hot controller states
   localparam [15:0] ST_RESET = 16'h0001;
   localparam [15:0] ST_IDLE = 16'h0002;
   localparam [15:0] ST_SEL_DR = 16'h0004;
   localparam [15:0] ST_CAP_DR = 16'h0008;
   localparam [15:0] ST_SH_DR = 16'h0010;
   localparam [15:0] ST_EX1_DR = 16'h0020;
   localparam [15:0] ST_PAU_DR = 16'h0040;
   localparam [15:0] ST_EX2_DR = 16'h0080;
   localparam [15:0] ST_UPD_DR = 16'h0100;
   localparam [15:0] ST_SEL_IR = 16'h0200;
   localparam [15:0] ST_CAP_IR = 16'h0400;
   localparam [15:0] ST_SH_IR = 16'h0800;
   localparam [15:0] ST_EX1_IR = 16'h1000;
   localparam [15:0] ST_PAU_IR = 16'h2000;
   localparam [15:0] ST_EX2_IR = 16'h4000;
   localparam [15:0] ST_UPD_IR = 16'h8000;

   // ==========================================================
   // Pin synchronisers and test clock edges
   reg tck_s1_q, tck_s2_q, tck_s3_q;
   reg tms_s1_q, tms_s2_q;
   reg tdi_s1_q, tdi_s2_q;
   wire tck_rise, tck_fall;

   // Two flops per pin plus a third on tck for edge detect; same depth keeps tms/tdi aligned with tck
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         tck_s1_q <= 1'b0;
         tck_s2_q <= 1'b0;
         tck_s3_q <= 1'b0;
         tms_s1_q <= 1'b1;
         tms_s2_q <= 1'b1;
         tdi_s1_q <= 1'b1;
         tdi_s2_q <= 1'b1;
      end else begin
         tck_s1_q <= i_tck;
         tck_s2_q <= tck_s1_q;
         tck_s3_q <= tck_s2_q;
         tms_s1_q <= i_tms;
         tms_s2_q <= tms_s1_q;
         tdi_s1_q <= i_tdi;
         tdi_s2_q <= tdi_s1_q;
      end
   end

   assign tck_rise = tck_s2_q & ~tck_s3_q;
   assign tck_fall = ~tck_s2_q & tck_s3_q;

   // ==========================================================
   // Controller state machine
   reg [15:0] state_q, state_d;

   // Standard 16-state walk; five TMS highs always reach reset
   always @* begin
      case (state_q)
         ST_RESET: state_d = tms_s2_q ? ST_RESET : ST_IDLE;
         ST_IDLE: state_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: state_d = tms_s2_q ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_d = tms_s2_q ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: state_d = tms_s2_q ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: state_d = tms_s2_q ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: state_d = tms_s2_q ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: state_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_d = tms_s2_q ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: state_d = tms_s2_q ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: state_d = tms_s2_q ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
         default: state_d = ST_RESET;
      endcase
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         state_q <= ST_RESET;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Instruction register and decode
   reg [`BSTAP_IR_LEN-1:0] ir_sh_q;
   reg [`BSTAP_IR_LEN-1:0] ir_q;
   wire sel_id, sel_uc, sel_bsr, drive_bsr, force_hiz;

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         ir_sh_q <= `BSTAP_IR_CAPTURE;
         ir_q <= `BSTAP_OP_IDCODE;
      end else if (tck_rise) begin
         if (state_q == ST_RESET) begin
            ir_q <= `BSTAP_OP_IDCODE;
         end else if (state_q == ST_CAP_IR) begin
            ir_sh_q <= `BSTAP_IR_CAPTURE;
         end else if (state_q == ST_SH_IR) begin
            ir_sh_q <= {tdi_s2_q, ir_sh_q[`BSTAP_IR_LEN-1:1]};
         end else if (state_q == ST_UPD_IR) begin
            ir_q <= ir_sh_q;
         end
      end
   end

   // Unknown codes fall to bypass, as do CLAMP and HIGHZ
   assign sel_id = (ir_q == `BSTAP_OP_IDCODE);
   assign sel_uc = (ir_q == `BSTAP_OP_USERCODE);
   assign sel_bsr = (ir_q == `BSTAP_OP_EXTEST) ||
                    (ir_q == `BSTAP_OP_SAMPLE);
   assign drive_bsr = (ir_q == `BSTAP_OP_EXTEST) ||
                      (ir_q == `BSTAP_OP_CLAMP);
   assign force_hiz = (ir_q == `BSTAP_OP_HIGHZ);

   // ==========================================================
   // Data registers
   reg byp_q;
   reg [`BSTAP_ID_LEN-1:0] id_sh_q;
   reg [`BSTAP_UC_LEN-1:0] uc_sh_q;
   reg [BSR_LEN-1:0] bsr_sh_q;
   reg [BSR_LEN-1:0] bsr_upd_q;
   wire [`BSTAP_ID_LEN-1:0] id_word;

   // Version, part, maker, then fixed bit
   assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

   // Capture, shift and update of the selected data register
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         byp_q <= 1'b0;
         id_sh_q <= {`BSTAP_ID_LEN{1'b0}};
         uc_sh_q <= {`BSTAP_UC_LEN{1'b0}};
         bsr_sh_q <= {BSR_LEN{1'b0}};
         bsr_upd_q <= {BSR_LEN{1'b0}};
      end else if (tck_rise) begin
         if (state_q == ST_CAP_DR) begin
            byp_q <= 1'b0;
            id_sh_q <= id_word;
            uc_sh_q <= i_usercode;
            if (sel_bsr) begin
               bsr_sh_q <= i_bsr_capture;
            end
         end else if (state_q == ST_SH_DR) begin
            byp_q <= tdi_s2_q;
            id_sh_q <= {tdi_s2_q, id_sh_q[`BSTAP_ID_LEN-1:1]};
            uc_sh_q <= {tdi_s2_q, uc_sh_q[`BSTAP_UC_LEN-1:1]};
            if (sel_bsr) begin
               bsr_sh_q <= {tdi_s2_q, bsr_sh_q[BSR_LEN-1:1]};
            end
         end else if (state_q == ST_UPD_DR && sel_bsr) begin
            bsr_upd_q <= bsr_sh_q;
         end
      end
   end

   assign o_bsr_update = bsr_upd_q;

   // ==========================================================
   // Serial output, changed on the test clock falling edge
   reg tdo_q, tdo_oe_q, tdo_d;

   // Output mux picks the chain's low bit
   always @* begin
      if (state_q == ST_SH_IR) begin
         tdo_d = ir_sh_q[0];
      end else if (sel_id) begin
         tdo_d = id_sh_q[0];
      end else if (sel_uc) begin
         tdo_d = uc_sh_q[0];
      end else if (sel_bsr) begin
         tdo_d = bsr_sh_q[0];
      end else begin
         tdo_d = byp_q;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= tdo_d;
         tdo_oe_q <= (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
      end
   end

   assign o_tdo = tdo_q;
   assign o_tdo_oe = tdo_oe_q;

   // ==========================================================
   // User I/O steering
   reg [NUM_IO-1:0] pin_out_q, pin_oe_q, keeper_q;

   // Cells 0..NUM_IO-1 hold data, next NUM_IO hold enables
   always @(posedge i_core_clk) begin
      // Keeper copy ignores reset and test modes alike
      keeper_q <= i_keeper_en;
      if (i_rst) begin
         pin_out_q <= {NUM_IO{1'b0}};
         pin_oe_q <= {NUM_IO{1'b0}};
      end else if (force_hiz) begin
         pin_out_q <= {NUM_IO{1'b0}};
         pin_oe_q <= {NUM_IO{1'b0}};
      end else if (drive_bsr) begin
         pin_out_q <= bsr_upd_q[NUM_IO-1:0];
         pin_oe_q <= bsr_upd_q[2*NUM_IO-1:NUM_IO];
      end else begin
         pin_out_q <= i_core_out;
         pin_oe_q <= i_core_oe;
      end
   end

   assign o_pin_out = pin_out_q;
   assign o_pin_oe = pin_oe_q;
   assign o_keeper_on = keeper_q;

endmodule // bstap_regs

// >>> testbench/bst_host_model.sv
// Test controller model driving the test access port pins
`timescale 1ns/100ps
module bst_host_model (
   // Core clock paces the test clock
   input wire i_core_clk,
   // Test port pins
   output logic o_tck = 1'b0,
   output logic o_tms = 1'b1,
   output logic o_tdi = 1'b0,
   input wire i_tdo,
   input wire i_tdo_oe
);
   // ===========================================================
   // One test clock: pins move at the fall, tdo is read before rise
   task automatic tick(logic ms, logic di, output logic dq);
      o_tms = ms;
      o_tdi = di;
      repeat (4) @(negedge i_core_clk);
      dq = i_tdo_oe ? i_tdo : 1'bx; // Undriven tdo never matches
      o_tck = 1'b1;
      repeat (4) @(negedge i_core_clk);
      o_tck = 1'b0;
   endtask
   // Walk to shift, move n bits, update, idle; tdi toggles off-frame
   task automatic scan(logic ir, int n, logic [2047:0] din,
      output logic [2047:0] dq);
      logic b;
      tick(1'b0, ~o_tdi, b);
      tick(1'b1, ~o_tdi, b);
      if (ir) tick(1'b1, ~o_tdi, b);
      tick(1'b0, ~o_tdi, b);
      tick(1'b0, ~o_tdi, b);
      for (int k = 0; k < n; k++) tick(k == n - 1, din[k], dq[k]);
      tick(1'b1, ~o_tdi, b);
      tick(1'b0, ~o_tdi, b);
   endtask
   // Five high mode bits reach test-logic-reset from any state
   task automatic reset5();
      logic b;
      repeat (5) tick(1'b1, ~o_tdi, b);
   endtask
endmodule // bst_host_model

// >>> testbench/bst_regs_checker.sv
// Port checker for the boundary-scan register block
`timescale 1ns/100ps
module bst_regs_checker #(
   parameter SIZE_VARIANT = 0,
   parameter NUM_IO = 8
) (
   // Clock, reset and test pins
   input wire i_core_clk,
   input wire i_rst,
   input wire i_tck,
   input wire o_tdo,
   input wire o_tdo_oe,
   // User I/O
   input wire [NUM_IO-1:0] i_core_out,
   input wire [NUM_IO-1:0] i_core_oe,
   input wire [NUM_IO-1:0] i_keeper_en,
   input wire [NUM_IO-1:0] o_pin_out,
   input wire [NUM_IO-1:0] o_pin_oe,
   input wire [NUM_IO-1:0] o_keeper_on
);
   // ===========================================================
   // Age of the last test clock fall; saturates so stalls are safe
   reg tck_q;
   reg [3:0] age_q;
   always @(posedge i_core_clk) begin
      tck_q <= i_tck;
      if (i_rst) age_q <= 4'hF;
      else if (tck_q && !i_tck) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence s_tck_high;
      i_tck [*3];
   endsequence
   sequence s_left_reset;
      $fell(i_rst) ##1 1'b1;
   endsequence
   a_tdo_on_fall: assert property (
      $changed(o_tdo) |-> age_q inside {[1:4]}) else $error("tdo moved");
   a_oe_on_fall: assert property (
      $changed(o_tdo_oe) |-> age_q inside {[1:4]}) else $error("oe moved");
   a_tdo_high_hold: assert property (
      s_tck_high |-> $stable(o_tdo)) else $error("tdo not standing");
   a_keeper_pass: assert property (
      o_keeper_on == $past(i_keeper_en)) else $error("keeper lost");
   a_pin_out_func: assert property (
      s_left_reset |-> o_pin_out == $past(i_core_out)) else $error("pin out");
   a_pin_oe_func: assert property (
      s_left_reset |-> o_pin_oe == $past(i_core_oe)) else $error("pin oe");
   a_reset_quiet: assert property (disable iff (1'b0)
      i_rst |=> !o_tdo_oe && !o_tdo) else $error("tdo busy in reset");
   a_oe_rise_data: assert property (
      $rose(o_tdo_oe) |-> age_q <= 4'h4) else $error("oe rose late");
endmodule // bst_regs_checker
bind bstap_regs bst_regs_checker #(.SIZE_VARIANT(SIZE_VARIANT),
   .NUM_IO(NUM_IO)) i_bst_checker (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_tck(i_tck), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
   .i_core_out(i_core_out), .i_core_oe(i_core_oe),
   .i_keeper_en(i_keeper_en), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
   .o_keeper_on(o_keeper_on));

// >>> testbench/testbench.sv
// Self-checking bench for the boundary-scan register block
`timescale 1ns/100ps
`include "bstap_map.vh"
module testbench;
   // ===========================================================
   // Signals, queue model and counters
   localparam int BSR = `BSTAP_BSR_LEN_SMALL;
   localparam logic [31:0] ID = {`BSTAP_ID_VER_RST, `BSTAP_ID_PART_RST,
      `BSTAP_ID_MFR_RST, 1'b1};
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   wire i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe;
   logic [31:0] i_usercode = 32'h0000_0000;
   logic [BSR-1:0] i_bsr_capture = '0;
   logic [BSR-1:0] cells = '0;
   wire [BSR-1:0] o_bsr_update;
   logic [7:0] i_core_out = 8'h00, i_core_oe = 8'h00, i_keeper_en = 8'h00;
   wire [7:0] o_pin_out, o_pin_oe, o_keeper_on;
   logic [2047:0] din, dout;
   logic [9:0] op;
   logic hiz;
   logic [9:0] ops [8] = '{`BSTAP_OP_SAMPLE, `BSTAP_OP_EXTEST, `BSTAP_OP_CLAMP,
      `BSTAP_OP_HIGHZ, `BSTAP_OP_USERCODE, `BSTAP_OP_BYPASS, 10'h155,
      `BSTAP_OP_IDCODE};
   int n_errors = 0;
   int num_checks = 0;
   int exp_q[$];
   bstap_regs #(.SIZE_VARIANT(0), .NUM_IO(8)) i_bstap_regs (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms),
      .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
      .i_usercode(i_usercode), .i_bsr_capture(i_bsr_capture),
      .o_bsr_update(o_bsr_update), .i_core_out(i_core_out),
      .i_core_oe(i_core_oe), .i_keeper_en(i_keeper_en),
      .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_keeper_on(o_keeper_on));
   bst_host_model i_host (.i_core_clk(i_core_clk), .o_tck(i_tck),
      .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));
   initial forever #12.5 i_core_clk = ~i_core_clk;
   // Compare one value and count it
   task automatic chk(string nm, logic [BSR-1:0] e, logic [BSR-1:0] s);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   // Queue the captured bits a scan should return first
   task automatic cap(logic [31:0] v, int w);
      for (int k = 0; k < w; k++) exp_q.push_back(v[k]);
   endtask
   // Scan n random bits, or for ir the code in the top 10 bits; captured bits then tdi come back out
   task automatic run(logic ir, int n, logic [9:0] code);
      for (int k = 0; k < n; k++) din[k] = 1'($urandom);
      if (ir) din[n-10 +: 10] = code;
      i_host.scan(ir, n, din, dout);
      for (int k = 0; k < n; k++) exp_q.push_back(din[k]);
      for (int k = 0; k < n; k++) chk("tdo", exp_q.pop_front(), dout[k]);
      exp_q.delete();
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ===========================================================
   // Main sequence: every instruction, then a mode-select reset
   initial begin
      void'($urandom(6));
      i_usercode = $urandom;
      i_core_out = 8'($urandom);
      i_core_oe = 8'($urandom);
      for (int k = 0; k < BSR; k++) i_bsr_capture[k] = 1'($urandom);
      repeat (4) @(negedge i_core_clk);
      i_rst = 1'b0;
      cap(ID, 32);
      run(1'b0, 40, 10'h000);
      foreach (ops[j]) begin
         op = ops[j];
         i_core_out = 8'($urandom);
         i_core_oe = 8'($urandom);
         i_keeper_en = 8'($urandom);
         cap(32'h0000_0001, 10);
         run(1'b1, 12, op);
         if (op == `BSTAP_OP_SAMPLE || op == `BSTAP_OP_EXTEST) begin
            for (int k = 0; k < BSR; k++) exp_q.push_back(i_bsr_capture[k]);
            run(1'b0, BSR + 8, 10'h000);
            cells = din[8 +: BSR];
            chk("bsr_update", cells, o_bsr_update);
         end else if (op == `BSTAP_OP_USERCODE || op == `BSTAP_OP_IDCODE) begin
            cap(op == `BSTAP_OP_IDCODE ? ID : i_usercode, 32);
            run(1'b0, 40, 10'h000);
         end else begin
            cap(32'h0000_0000, 1);
            run(1'b0, 9, 10'h000);
         end
         @(negedge i_core_clk);
         chk("keeper_on", i_keeper_en, o_keeper_on);
         if (op == `BSTAP_OP_EXTEST || op == `BSTAP_OP_CLAMP) begin
            chk("pin_out", cells[7:0], o_pin_out);
            chk("pin_oe", cells[15:8], o_pin_oe);
         end else begin
            hiz = (op == `BSTAP_OP_HIGHZ);
            chk("pin_out", hiz ? 8'h00 : i_core_out, o_pin_out);
            chk("pin_oe", hiz ? 8'h00 : i_core_oe, o_pin_oe);
         end
      end
      cap(32'h0000_0001, 10);
      run(1'b1, 12, `BSTAP_OP_BYPASS);
      i_host.reset5();
      cap(ID, 32);
      run(1'b0, 40, 10'h000);
      conclude();
   end
   // Watchdog well beyond the roughly 0.5 ms the scans take
   initial begin
      #2_000_000;
      n_errors++;
      $display("[ERR] run expected done seen hang");
      conclude();
   end
endmodule // testbench
